/* scd_board_straps.sv */
// board strap resistors seen as four resolved bits per pin
// assumes the bench picks a setting before each reset
`timescale 1ns/10ps
module scd_board_straps (
  input  wire logic [7:0][3:0] i_setting,
  output logic      [7:0][3:0] o_config_strap_pin
);
  // reserved bits stay tied low whatever the setting asks
  always_comb begin
    o_config_strap_pin = i_setting;
    o_config_strap_pin[7][3] = 1'b0;
    o_config_strap_pin[5][2] = 1'b0;
  end
endmodule : scd_board_straps

/* scd_pkg.sv */
// constants, register map and carriers for the strap configuration decoder
// assumes one 20 MHz clock and management access by page, address, data
//
// Summary of operation
// RULE_01 - global led swap register bits 1:0 read/write, reset 00, rest zero
// RULE_02 - eight strap pins each give four bits, sixteen settings per pin
// RULE_03 - every decoded strap bit becomes default of one register field; pins 2,1,0 bit 3 and pin 4 bit 1 feed o_phy_addr only
// RULE_04 - board ties pin 7 bit 3 and pin 5 bit 2 low
// RULE_05 - pin 7 bit 2 sets speed downshift enable, register 20E bit 4
// RULE_06 - pin 7 bits 1:0 set advertised speeds in registers 4 and 9
// RULE_07 - pin 6 bit 3 mac autoneg reg 23.13; bit 2 low power reg 28.6
// RULE_08 - pin 6 bit 1 asymmetric pause 4.11; bit 0 symmetric pause 4.10
// RULE_09 - media field 23 bits 10:8 from bit 3 of pins 5,4,3
// RULE_10 - media codes 000 to 011: copper, passthrough, 1000x, 100x fiber
// RULE_11 - codes 101,110,111 auto sense copper with fiber mode; 100 reserved
// RULE_12 - pin 5 bit 1 aux clock 125/156.25 MHz; bit 0 aux clock enable
// RULE_13 - pin 4: signal detect polarity, address reversal, led fiber combine
// RULE_14 - pin n feeds led n combine on bit 2, function on bits 1:0
// RULE_15 - bit 3 of pins 2,1,0 give phy address bits 4,3,2
// RULE_16 - reversal clear: port n gets low address n; set: reversed order
// RULE_17 - strap results are only defaults; fields stay software writable
// RULE_18 - straps latched in reset, loaded at release, later changes ignored
package scd_pkg;

  localparam int NREG = 10;
  localparam int NPIN = 8;
  localparam int NLED = 4;

  // pages of the management space
  localparam logic [1:0] PG_STD = 2'h0;
  localparam logic [1:0] PG_EXT = 2'h1;
  localparam logic [1:0] PG_GLB = 2'h2;

  // register table index
  localparam int I_ADV  = 0;
  localparam int I_GIG  = 1;
  localparam int I_AUXE = 2;
  localparam int I_SIG  = 3;
  localparam int I_DSH  = 4;
  localparam int I_MAC  = 5;
  localparam int I_LPL  = 6;
  localparam int I_LEDF = 7;
  localparam int I_LEDC = 8;
  localparam int I_SWAP = 9;

  localparam logic [1:0] REG_PG [NREG] = '{
    PG_STD, PG_STD, PG_STD, PG_EXT, PG_EXT,
    PG_STD, PG_STD, PG_STD, PG_STD, PG_GLB};
  localparam logic [4:0] REG_ADDR [NREG] = '{
    5'h04, 5'h09, 5'h12, 5'h13, 5'h14,
    5'h17, 5'h1C, 5'h1D, 5'h1E, 5'h19};
  localparam logic [15:0] REG_WMASK [NREG] = '{
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0003};
  localparam logic [15:0] SWAP_RST = 16'h0000;
  localparam logic [15:0] REG_ZERO = 16'h0000;

  // field positions inside registers
  localparam int B_SPD_LO = 5;
  localparam int B_GIG_LO = 8;
  localparam int B_SYM    = 10;
  localparam int B_ASYM   = 11;
  localparam int B_AUXEN  = 0;
  localparam int B_SIGPOL = 0;
  localparam int B_DSH    = 4;
  localparam int B_AUXSPD = 8;
  localparam int B_MEDIA  = 8;
  localparam int B_MACAN  = 13;
  localparam int B_LPL    = 6;
  localparam int B_LEDFC  = 15;

  // strap pin and bit positions
  localparam int P_SPD = 7;
  localparam int P_MAC = 6;
  localparam int P_AUX = 5;
  localparam int P_MED2 = 5;
  localparam int P_MED1 = 4;
  localparam int P_MED0 = 3;
  localparam int P_MISC = 4;
  localparam int P_AD4 = 2;
  localparam int P_AD3 = 1;
  localparam int P_AD2 = 0;
  localparam int S_HI = 3;
  localparam int S_MID = 2;
  localparam int S_B1 = 1;
  localparam int S_B0 = 0;

  // speed advertisement per strap code: reg 4 bits 8:5, reg 9 bits 9:8
  // code 01 keeps every 10/100 ability and drops only gigabit half duplex
  localparam logic [3:0] ADV_ALL = 4'hF;
  localparam logic [3:0] ADV_NONE = 4'h0;
  localparam logic [1:0] GIG_ALL = 2'h3;
  localparam logic [1:0] GIG_FDX = 2'h2;
  localparam logic [1:0] GIG_NONE = 2'h0;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b01,
    ST_RUN  = 2'b10
  } scd_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [1:0]  page;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } scd_req_t;

  typedef struct packed {
    logic            downshift;
    logic [3:0]      adv_10_100;
    logic [1:0]      adv_1000;
    logic            pause_asym;
    logic            pause_sym;
    logic            mac_autoneg;
    logic            low_power_link_mode;
    logic [2:0]      media;
    logic            aux_clock_output_fast;
    logic            aux_clock_output_en;
    logic            signal_detect_input_low;
    logic            led_fiber_sep;
    logic [3:0]      led_status_only;
    logic [3:0][3:0] led_func;
    logic [1:0]      led_swap;
  } scd_cfg_t;

  typedef struct packed {
    logic copper;
    logic fiber_pass;
    logic fiber_1000x;
    logic fiber_100fx;
    logic auto_sense;
    logic reserved;
  } scd_media_t;

endpackage : scd_pkg

/* scd_strap_config.sv */
// strap pin decoder and the register fields whose defaults it supplies
// assumes strap pins are static board levels resolved to four bits each
`timescale 1ns/10ps
module scd_strap_config (
  input  wire logic                      i_mclk,
  input  wire logic                      i_srst,
  input  wire logic [7:0][3:0]           i_config_strap_pin,
  input  wire scd_pkg::scd_req_t         i_req,
  output logic      [15:0]               o_rdata,
  output logic                           o_rvalid,
  output logic                           o_hit,
  output scd_pkg::scd_cfg_t              o_cfg,
  output scd_pkg::scd_media_t            o_media,
  output logic      [3:0][4:0]           o_phy_addr
);
  import scd_pkg::*;

  // strap synchroniser, first stage read only by second
  logic [7:0][3:0] strap_s1;
  logic [7:0][3:0] strap_s2;
  logic [7:0][3:0] strap_q;
  logic [7:0][3:0] next_strap_q;

  scd_state_t      state;
  scd_state_t      next_state;
  logic [15:0]     regs      [NREG];
  logic [15:0]     next_regs [NREG];
  logic [15:0]     defs      [NREG];
  logic [15:0]     next_rdata;
  logic            next_rvalid;
  logic            next_hit;
  logic [3:0]      idx;
  logic            hit;
  logic [3:0][4:0] next_phy_addr;
  scd_media_t      next_media;

  always_ff @(posedge i_mclk) begin
    strap_s1 <= i_config_strap_pin; // RULE_02
    strap_s2 <= strap_s1;
  end

  // keep sampling while reset is held; freeze at release
  always_comb begin
    next_strap_q = strap_q;
    if (i_srst) begin
      next_strap_q = strap_s2; // RULE_18
    end
  end

  always_ff @(posedge i_mclk) begin
    strap_q <= next_strap_q;
  end

  // defaults built from the latched straps
  always_comb begin
    for (int r = 0; r < NREG; r++) begin
      defs[r] = REG_ZERO;
    end
    case (strap_q[P_SPD][S_B1:S_B0]) // RULE_06
      2'h0: begin
        defs[I_ADV][B_SPD_LO +: 4] = ADV_ALL;
        defs[I_GIG][B_GIG_LO +: 2] = GIG_ALL;
      end
      2'h1: begin
        defs[I_ADV][B_SPD_LO +: 4] = ADV_ALL;
        defs[I_GIG][B_GIG_LO +: 2] = GIG_FDX;
      end
      2'h2: begin
        defs[I_ADV][B_SPD_LO +: 4] = ADV_NONE;
        defs[I_GIG][B_GIG_LO +: 2] = GIG_FDX;
      end
      2'h3: begin
        defs[I_ADV][B_SPD_LO +: 4] = ADV_ALL;
        defs[I_GIG][B_GIG_LO +: 2] = GIG_NONE;
      end
      default: begin
        defs[I_ADV][B_SPD_LO +: 4] = ADV_ALL;
        defs[I_GIG][B_GIG_LO +: 2] = GIG_ALL;
      end
    endcase
    defs[I_DSH][B_DSH]     = strap_q[P_SPD][S_MID]; // RULE_05
    defs[I_MAC][B_MACAN]   = strap_q[P_MAC][S_HI]; // RULE_07
    defs[I_LPL][B_LPL]     = strap_q[P_MAC][S_MID]; // RULE_07
    defs[I_ADV][B_ASYM]    = strap_q[P_MAC][S_B1]; // RULE_08
    defs[I_ADV][B_SYM]     = strap_q[P_MAC][S_B0]; // RULE_08
    defs[I_MAC][B_MEDIA +: 3] = {strap_q[P_MED2][S_HI],
                                 strap_q[P_MED1][S_HI],
                                 strap_q[P_MED0][S_HI]}; // RULE_09
    defs[I_DSH][B_AUXSPD]  = strap_q[P_AUX][S_B1]; // RULE_12
    defs[I_AUXE][B_AUXEN]  = strap_q[P_AUX][S_B0]; // RULE_12
    defs[I_SIG][B_SIGPOL]  = strap_q[P_MISC][S_MID]; // RULE_13
    defs[I_LEDC][B_LEDFC]  = strap_q[P_MISC][S_B0]; // RULE_13
    for (int n = 0; n < NLED; n++) begin
      defs[I_LEDC][n] = strap_q[n][S_MID]; // RULE_14
      defs[I_LEDF][4*n +: 2] = strap_q[n][S_B1:S_B0]; // RULE_14
    end
    defs[I_SWAP] = SWAP_RST; // RULE_01
  end

  // register address decode against the map table
  always_comb begin
    idx = 4'h0;
    hit = 1'b0;
    for (int r = 0; r < NREG; r++) begin
      if (i_req.page == REG_PG[r] && i_req.addr == REG_ADDR[r]) begin
        idx = 4'(r);
        hit = 1'b1;
      end
    end
  end

  // sequencing: one load edge after release, then software access
  always_comb begin
    next_state = state;
    case (state)
      ST_HOLD: next_state = ST_RUN;
      ST_RUN:  next_state = ST_RUN;
      default: next_state = ST_HOLD;
    endcase
    if (i_srst) begin
      next_state = ST_HOLD;
    end
  end

  always_comb begin
    for (int r = 0; r < NREG; r++) begin
      next_regs[r] = regs[r];
    end
    if (i_srst) begin
      for (int r = 0; r < NREG; r++) begin
        next_regs[r] = REG_ZERO;
      end
    end else if (state == ST_HOLD) begin
      for (int r = 0; r < NREG; r++) begin
        next_regs[r] = defs[r]; // RULE_03
      end
    end else if (i_req.wr && hit) begin
      // reserved bits are masked off so they read back as zero
      next_regs[idx] = i_req.wdata & REG_WMASK[idx]; // RULE_17
    end
  end

  always_ff @(posedge i_mclk) begin
    state <= next_state;
    for (int r = 0; r < NREG; r++) begin
      regs[r] <= next_regs[r];
    end
  end

  // read port: registered data, unmapped address answers zero
  always_comb begin
    next_rdata  = REG_ZERO;
    next_rvalid = 1'b0;
    next_hit    = 1'b0;
    if (!i_srst && state == ST_RUN && i_req.rd) begin
      next_rvalid = 1'b1;
      next_hit    = hit;
      if (hit) begin
        next_rdata = regs[idx];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    o_rdata  <= next_rdata;
    o_rvalid <= next_rvalid;
    o_hit    <= next_hit;
  end

  // phy addresses from latched straps; never follow the pins later
  always_comb begin
    for (int p = 0; p < NLED; p++) begin
      next_phy_addr[p][4:2] = {strap_q[P_AD4][S_HI],
                               strap_q[P_AD3][S_HI],
                               strap_q[P_AD2][S_HI]}; // RULE_15
      if (strap_q[P_MISC][S_B1]) begin
        next_phy_addr[p][1:0] = 2'(3 - p); // RULE_16
      end else begin
        next_phy_addr[p][1:0] = 2'(p); // RULE_16
      end
    end
    if (i_srst) begin
      next_phy_addr = '0;
    end
  end

  always_ff @(posedge i_mclk) begin
    o_phy_addr <= next_phy_addr;
  end

  // media mode decode of the live register field
  always_comb begin
    next_media = '0;
    case (regs[I_MAC][B_MEDIA +: 3])
      3'h0: next_media.copper = 1'b1; // RULE_10
      3'h1: next_media.fiber_pass = 1'b1; // RULE_10
      3'h2: next_media.fiber_1000x = 1'b1; // RULE_10
      3'h3: next_media.fiber_100fx = 1'b1; // RULE_10
      3'h5: begin
        next_media.auto_sense = 1'b1; // RULE_11
        next_media.copper     = 1'b1;
        next_media.fiber_pass = 1'b1;
      end
      3'h6: begin
        next_media.auto_sense  = 1'b1; // RULE_11
        next_media.copper      = 1'b1;
        next_media.fiber_1000x = 1'b1;
      end
      3'h7: begin
        next_media.auto_sense  = 1'b1; // RULE_11
        next_media.copper      = 1'b1;
        next_media.fiber_100fx = 1'b1;
      end
      default: next_media.reserved = 1'b1; // RULE_11
    endcase
    if (i_srst) begin
      next_media = '0;
    end
  end

  always_ff @(posedge i_mclk) begin
    o_media <= next_media;
  end

  // settings view: slices of flops, so it follows software writes
  always_comb begin
    o_cfg.downshift           = regs[I_DSH][B_DSH];
    o_cfg.adv_10_100          = regs[I_ADV][B_SPD_LO +: 4];
    o_cfg.adv_1000            = regs[I_GIG][B_GIG_LO +: 2];
    o_cfg.pause_asym          = regs[I_ADV][B_ASYM];
    o_cfg.pause_sym           = regs[I_ADV][B_SYM];
    o_cfg.mac_autoneg         = regs[I_MAC][B_MACAN];
    o_cfg.low_power_link_mode = regs[I_LPL][B_LPL];
    o_cfg.media               = regs[I_MAC][B_MEDIA +: 3];
    o_cfg.aux_clock_output_fast   = regs[I_DSH][B_AUXSPD];
    o_cfg.aux_clock_output_en     = regs[I_AUXE][B_AUXEN];
    o_cfg.signal_detect_input_low = regs[I_SIG][B_SIGPOL];
    o_cfg.led_fiber_sep       = regs[I_LEDC][B_LEDFC];
    o_cfg.led_status_only     = regs[I_LEDC][NLED-1:0];
    for (int n = 0; n < NLED; n++) begin
      o_cfg.led_func[n] = regs[I_LEDF][4*n +: 4];
    end
    o_cfg.led_swap            = regs[I_SWAP][1:0]; // RULE_01
  end

endmodule : scd_strap_config

/* scd_strap_config_checker.sv */
// port checker for the strap decoder
// assumes a bind onto scd_strap_config, one clock
`timescale 1ns/10ps
module scd_checker (
  input wire logic                i_mclk,
  input wire logic                i_srst,
  input wire scd_pkg::scd_req_t   i_req,
  input wire logic [15:0]         o_rdata,
  input wire logic                o_rvalid,
  input wire logic                o_hit,
  input wire scd_pkg::scd_cfg_t   o_cfg,
  input wire scd_pkg::scd_media_t o_media,
  input wire logic [3:0][4:0]     o_phy_addr
);
  import scd_pkg::*;
  logic [1:0] age;
  logic [1:0] next_age;
  logic       run;
  logic       took;
  // age 0 marks the load edge, where requests are dropped
  always_comb begin
    next_age = (age == 2'h3) ? age : age + 2'h1;
    if (i_srst) next_age = 2'h0;
  end
  always_ff @(posedge i_mclk) begin
    age <= next_age;
  end
  assign run = !i_srst && age != 2'h0;
  assign took = run && i_req.rd;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  property p_rd_ans;
    took |=> o_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read lost");
  property p_rv_cause;
    o_rvalid |-> $past(took);
  endproperty
  a_rv_cause: assert property (p_rv_cause) else $error("no read");
  property p_swap;
    o_rvalid && $past(i_req.page) == PG_GLB && $past(i_req.addr) == 5'h19
      |-> o_hit && o_rdata[15:2] == 14'h0000;
  endproperty
  a_swap: assert property (p_swap) else $error("swap upper bits");
  property p_rst;
    !i_srst && age == 2'h0 |-> !o_rvalid && o_cfg == '0 &&
      o_phy_addr == '0 && o_media == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values");
  property p_frozen;
    age == 2'h3 && !$past(i_req.wr) |-> $stable(o_cfg);
  endproperty
  a_frozen: assert property (p_frozen) else $error("config moved");
  property p_phy_hold;
    age == 2'h3 |-> $stable(o_phy_addr);
  endproperty
  a_phy_hold: assert property (p_phy_hold) else $error("phy moved");
  property p_phy_ord;
    run |-> {o_phy_addr[0][1:0], o_phy_addr[3][1:0]} inside {4'h3, 4'hC};
  endproperty
  a_phy_ord: assert property (p_phy_ord) else $error("port order");
  property p_med_lo;
    age == 2'h3 && $stable(o_cfg.media) && !o_cfg.media[2]
      |-> o_media == 6'h20 >> o_cfg.media;
  endproperty
  a_med_lo: assert property (p_med_lo) else $error("media mode");
  property p_med_hi;
    age == 2'h3 && $stable(o_cfg.media) |->
      {o_media.auto_sense, o_media.reserved} ==
      {o_cfg.media > 3'h4, o_cfg.media == 3'h4};
  endproperty
  a_med_hi: assert property (p_med_hi) else $error("media sense");
  c_hit: cover property (o_rvalid && o_hit);
  c_miss: cover property (o_rvalid && !o_hit);
  c_resv: cover property (o_media.reserved);
endmodule : scd_checker

bind scd_strap_config scd_checker i_chk (.i_mclk, .i_srst, .i_req,
  .o_rdata, .o_rvalid, .o_hit, .o_cfg, .o_media, .o_phy_addr);

/* scd_strap_config_tb_top.sv */
// self-checking bench for the strap decoder
// assumes the strap model and the checker are compiled first
`timescale 1ns/10ps
module scd_strap_config_tb_top;
  import scd_pkg::*;
  logic            i_mclk = 1'b0;
  logic            i_srst = 1'b1;
  logic [7:0][3:0] setting = '0;
  logic [7:0][3:0] pins;
  scd_req_t        req = '0;
  logic [15:0]     rdata;
  logic            rvalid;
  logic            hit;
  scd_cfg_t        cfg;
  scd_media_t      media;
  logic [3:0][4:0] phy;
  int              n_errors = 0;
  int              num_checks = 0;

  always #25 i_mclk = ~i_mclk;

  scd_board_straps i_board (.i_setting(setting), .o_config_strap_pin(pins));
  scd_strap_config i_dut (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_config_strap_pin(pins),
    .i_req(req), .o_rdata(rdata), .o_rvalid(rvalid), .o_hit(hit),
    .o_cfg(cfg), .o_media(media), .o_phy_addr(phy)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wr_reg(input logic [1:0] pg, input logic [4:0] ad,
                        input logic [15:0] d);
    @(posedge i_mclk);
    req <= '{1'b1, 1'b0, pg, ad, d};
    @(posedge i_mclk);
    req.wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [1:0] pg, input logic [4:0] ad,
                        input logic [16:0] exp);
    int i;
    @(posedge i_mclk);
    req <= '{1'b0, 1'b1, pg, ad, 16'h0000};
    @(posedge i_mclk);
    req.rd <= 1'b0;
    #1;
    for (i = 0; i < 4 && rvalid !== 1'b1; i++) begin
      @(posedge i_mclk);
      #1;
    end
    if (i == 4) begin
      chk(rvalid, 1'b1);
      tally_and_finish();
    end else chk({hit, rdata}, exp);
  endtask : rd_reg

  task automatic boot(input logic [7:0][3:0] s);
    @(posedge i_mclk);
    setting <= s;
    i_srst <= 1'b1;
    repeat (6) @(posedge i_mclk);
    // a write on the load edge must be dropped
    i_srst <= 1'b0;
    req <= '{1'b1, 1'b0, PG_GLB, 5'h19, 16'h0003};
    @(posedge i_mclk);
    req.wr <= 1'b0;
    @(posedge i_mclk);
  endtask : boot

  task automatic test_defaults(input logic [2:0] k);
    logic [7:0][3:0] s;
    logic [7:0][3:0] p;
    logic [5:0]      spd;
    logic [1:0]      lo;
    for (int n = 0; n < 8; n++) begin
      s[n] = 4'(k * 5 + n * 3);
    end
    s[5][3] = k[2];
    s[4][3] = k[1];
    s[3][3] = k[0];
    boot(s);
    p = pins;
    // pins flipped after release; nothing may follow them
    setting <= ~s;
    repeat (3) @(posedge i_mclk);
    #1;
    case (p[7][1:0])
      2'h0: spd = {ADV_ALL, GIG_ALL};
      2'h1: spd = {ADV_ALL, GIG_FDX};
      2'h2: spd = {ADV_NONE, GIG_FDX};
      default: spd = {ADV_ALL, GIG_NONE};
    endcase
    chk(cfg.downshift, p[7][2]);
    chk({cfg.adv_10_100, cfg.adv_1000}, spd);
    chk({cfg.mac_autoneg, cfg.low_power_link_mode}, p[6][3:2]);
    chk({cfg.pause_asym, cfg.pause_sym}, p[6][1:0]);
    chk(cfg.media, {p[5][3], p[4][3], p[3][3]});
    chk(cfg.aux_clock_output_fast, p[5][1]);
    chk(cfg.aux_clock_output_en, p[5][0]);
    chk(cfg.signal_detect_input_low, p[4][2]);
    chk(cfg.led_fiber_sep, p[4][0]);
    chk(cfg.led_swap, 2'h0);
    for (int n = 0; n < 4; n++) begin
      lo = 2'(p[4][1] ? 3 - n : n);
      chk(cfg.led_status_only[n], p[n][2]);
      chk(cfg.led_func[n], {2'h0, p[n][1:0]});
      chk(phy[n], {p[2][3], p[1][3], p[0][3], lo});
    end
    if (!k[2]) chk(media, 6'h20 >> k);
    else chk({media.auto_sense, media.reserved},
             {k != 3'h4, k == 3'h4});
    $display("test defaults %0d done", k);
  endtask : test_defaults

  task automatic test_regs();
    rd_reg(PG_GLB, 5'h19, {1'b1, 16'h0000});
    wr_reg(PG_GLB, 5'h19, 16'hFFFF);
    rd_reg(PG_GLB, 5'h19, {1'b1, 16'h0003});
    chk(cfg.led_swap, 2'h3);
    wr_reg(PG_STD, 5'h04, 16'h0C00);
    #1;
    chk({cfg.pause_asym, cfg.pause_sym, cfg.adv_10_100}, 6'h30);
    rd_reg(PG_STD, 5'h04, {1'b1, 16'h0C00});
    wr_reg(PG_EXT, 5'h14, 16'h0010);
    #1;
    chk(cfg.downshift, 1'b1);
    wr_reg(PG_STD, 5'h17, 16'h0400);
    repeat (2) @(posedge i_mclk);
    #1;
    chk({cfg.media, media.reserved}, 4'h9);
    rd_reg(2'h3, 5'h00, {1'b0, 16'h0000});
    $display("test regs done");
  endtask : test_regs

  initial begin
    for (int k = 0; k < 8; k++) begin
      test_defaults(3'(k));
    end
    test_regs();
    tally_and_finish();
  end
endmodule : scd_strap_config_tb_top
